// >>> uls_pkg.sv
package uls_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_W = 9;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] EP_COUNT = 4'h8;
   localparam logic [1:0] LINK_U0 = 2'h0;
   localparam logic [1:0] LINK_U1 = 2'h1;
   localparam logic [1:0] LINK_U2 = 2'h2;
   localparam logic [1:0] LINK_U3 = 2'h3;
   localparam logic XCVR_RST_INIT = 1'b0;
   localparam logic [7:0] BUS_IDLE = 8'h00;
   localparam logic [10:0] PIN_INIT = 11'h000;

   typedef enum logic [1:0] {
      L_IDLE = 2'h0,
      L_TX = 2'h1,
      L_LOAD = 2'h2,
      L_STOP = 2'h3
   } uls_link_e;

   typedef enum logic [1:0] {
      PS_FULL = 2'h0,
      PS_LIGHT_CLOCK_GATED = 2'h1,
      PS_POWER_GATED = 2'h2,
      PS_DEEP = 2'h3
   } uls_pwr_e;

   localparam uls_pwr_e PS_INIT = PS_POWER_GATED;
endpackage : uls_pkg

// >>> uls_strm_if.sv
interface uls_strm_if #(parameter int W = 9);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : uls_strm_if

// >>> uls_mem.sv
module uls_mem #(
   parameter int W = 9,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : uls_mem

// >>> uls_fifo.sv
module uls_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   uls_strm_if.snk in_s,
   uls_strm_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] cnt_r;
   logic fetch_r;
   logic out_v_r;
   logic push;
   logic fetch;

   // One word is fetched at a time, so the drain rate is at most a third of the clock.
   assign in_s.ready = (cnt_r != FULL_CNT);
   assign push = in_s.valid && in_s.ready;
   assign fetch = (cnt_r != '0) && !fetch_r && !out_v_r;
   assign out_s.valid = out_v_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (fetch) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (push && !fetch) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (fetch && !push) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_r <= 1'b0;
         out_v_r <= 1'b0;
      end else begin
         fetch_r <= fetch;
         if (fetch_r) begin
            out_v_r <= 1'b1;
         end else if (out_s.ready) begin
            out_v_r <= 1'b0;
         end
      end
   end

   uls_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .wr_en(push),
      .wr_addr(wr_ptr_r),
      .wr_data(in_s.data),
      .rd_en(fetch),
      .rd_addr(rd_ptr_r),
      .rd_data(out_s.data)
   );
endmodule : uls_fifo

// >>> uls_link.sv
module uls_link
   import uls_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ulpi_clk,
   input wire logic [7:0] ulpi_data_in,
   output logic [7:0] ulpi_data_out,
   output logic ulpi_data_oe,
   input wire logic ulpi_dir,
   input wire logic xcvr_pace,
   output logic link_stop,
   output logic xcvr_ref_clock,
   output logic xcvr_reset_n,
   input wire logic xcvr_release,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [3:0] tx_ep,
   output logic tx_ep_bad,
   input wire logic bus_req,
   output logic [7:0] rx_data,
   output logic rx_cmd,
   output logic rx_valid,
   input wire logic [1:0] link_state,
   input wire logic sw_suspend,
   input wire logic partner_attached,
   input wire logic sw_deep_req,
   output logic [1:0] power_state,
   output logic unit_clk_en,
   output logic ev_valid,
   output logic [1:0] ev_code,
   input wire logic ev_ready,
   output logic ev_irq
);
   function automatic logic link_low(input logic [1:0] st);
      link_low = (st == LINK_U1) || (st == LINK_U2);
   endfunction : link_low

   uls_strm_if #(.W(FIFO_W)) fin ();
   uls_strm_if #(.W(FIFO_W)) fq ();

   logic [10:0] pin_s1_r;
   logic [10:0] pin_s2_r;
   logic clk_prev_r;
   logic tick;
   logic dir_s;
   logic nxt_s;
   logic [7:0] din_s;
   logic dir_prev_r;
   logic turn;
   uls_link_e ls_r;
   uls_pwr_e ps_r;
   logic xrst_r;
   logic ref_r;
   logic tx_ok;
   logic pop;
   logic [1:0] link_prev_r;

   assign fin.valid = tx_valid;
   assign fin.data = {tx_last, tx_data};
   assign tx_ready = fin.ready;

   uls_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rst_n(rst_n),
      .in_s(fin),
      .out_s(fq)
   );

   // Pins come from the transceiver clock domain, so two stages first.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= PIN_INIT;
         pin_s2_r <= PIN_INIT;
         clk_prev_r <= 1'b0;
      end else begin
         pin_s1_r <= {ulpi_clk, ulpi_dir, xcvr_pace, ulpi_data_in};
         pin_s2_r <= pin_s1_r;
         clk_prev_r <= pin_s2_r[10];
      end
   end

   // All bus sampling and driving steps on the rising interface edge, except the L_LOAD byte reload and the transceiver-reset return to L_IDLE.
   assign tick = pin_s2_r[10] && !clk_prev_r;
   assign dir_s = pin_s2_r[9];
   assign nxt_s = pin_s2_r[8];
   assign din_s = pin_s2_r[7:0];
   assign turn = dir_s != dir_prev_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_prev_r <= 1'b0;
      end else if (tick) begin
         dir_prev_r <= dir_s;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ep_bad <= 1'b0;
      end else begin
         tx_ep_bad <= tx_ep >= EP_COUNT;
      end
   end

   assign tx_ok = xrst_r && (ps_r == PS_FULL) && !tx_ep_bad;
   // A zero head byte cannot open a transfer, so it is dropped.
   assign pop = tick && !dir_s && !turn && fq.valid && (
      (ls_r == L_IDLE && tx_ok && fq.data[7:0] == BUS_IDLE) ||
      (ls_r == L_TX && nxt_s));
   assign fq.ready = pop;

   // A FIFO underrun in mid-packet simply holds the link in L_LOAD.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ls_r <= L_IDLE;
         ulpi_data_out <= BUS_IDLE;
         link_stop <= 1'b0;
      end else if (!xrst_r && ls_r != L_IDLE) begin
         ls_r <= L_IDLE;
         ulpi_data_out <= BUS_IDLE;
         link_stop <= 1'b0;
      end else begin
         unique case (ls_r)
            L_IDLE: begin
               if (tick && dir_s && !turn && bus_req) begin
                  link_stop <= 1'b1;
                  ls_r <= L_STOP;
               end else if (tick && !dir_s && !turn && tx_ok &&
                            fq.valid && fq.data[7:0] != BUS_IDLE) begin
                  ulpi_data_out <= fq.data[7:0];
                  ls_r <= L_TX;
               end
            end
            L_TX: begin
               if (tick && dir_s) begin
                  ulpi_data_out <= BUS_IDLE;
                  ls_r <= L_IDLE;
               end else if (tick && nxt_s && !turn) begin
                  if (fq.data[8]) begin
                     ulpi_data_out <= BUS_IDLE;
                     link_stop <= 1'b1;
                     ls_r <= L_STOP;
                  end else begin
                     ls_r <= L_LOAD;
                  end
               end
            end
            L_LOAD: begin
               if (tick && dir_s) begin
                  ulpi_data_out <= BUS_IDLE;
                  ls_r <= L_IDLE;
               end else if (fq.valid) begin
                  ulpi_data_out <= fq.data[7:0];
                  ls_r <= L_TX;
               end
            end
            L_STOP: begin
               if (tick) begin
                  link_stop <= 1'b0;
                  ls_r <= L_IDLE;
               end
            end
         endcase
      end
   end

   // The pad is released on the edge where direction changes.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ulpi_data_oe <= 1'b0;
      end else if (tick) begin
         ulpi_data_oe <= !dir_s && !turn;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= BUS_IDLE;
         rx_cmd <= 1'b0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= tick && dir_s && !turn;
         if (tick && dir_s && !turn) begin
            rx_data <= din_s;
            rx_cmd <= !nxt_s;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xrst_r <= XCVR_RST_INIT;
      end else begin
         xrst_r <= xcvr_release;
      end
   end

   assign xcvr_reset_n = xrst_r;

   // U3 without a software request stays clock gated while the partner is attached, not power gated.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ps_r <= PS_INIT;
      end else if (sw_deep_req &&
                   (ps_r == PS_DEEP || link_state == LINK_U3)) begin
         ps_r <= PS_DEEP;
      end else if (sw_suspend || !partner_attached) begin
         ps_r <= PS_POWER_GATED;
      end else if (link_low(link_state) || link_state == LINK_U3) begin
         ps_r <= PS_LIGHT_CLOCK_GATED;
      end else begin
         ps_r <= PS_FULL;
      end
   end

   assign power_state = ps_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_clk_en <= 1'b0;
      end else begin
         unit_clk_en <= ps_r == PS_FULL;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_r <= 1'b0;
      end else if (ps_r == PS_FULL || ps_r == PS_LIGHT_CLOCK_GATED) begin
         ref_r <= !ref_r;
      end else begin
         ref_r <= 1'b0;
      end
   end

   assign xcvr_ref_clock = ref_r;

   // A new change wins over a same-cycle acceptance of the old one.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_prev_r <= LINK_U0;
         ev_valid <= 1'b0;
         ev_code <= LINK_U0;
         ev_irq <= 1'b0;
      end else begin
         link_prev_r <= link_state;
         ev_irq <= ev_valid && ev_ready;
         if (link_state != link_prev_r) begin
            ev_valid <= 1'b1;
            ev_code <= link_state;
         end else if (ev_ready) begin
            ev_valid <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_idle_bus_low: assert property (
      (ls_r == L_IDLE && ulpi_data_oe) |-> ulpi_data_out == BUS_IDLE)
      else $error("idle bus not low");
   a_start_nonzero: assert property (
      (ls_r == L_IDLE) ##1 (ls_r == L_TX) |-> ulpi_data_out != BUS_IDLE)
      else $error("transfer opened with zero");
   a_turn_release: assert property (
      (tick && turn) |=> !ulpi_data_oe [*2])
      else $error("bus driven in turnaround");
   a_pace_hold: assert property (
      (tick && ls_r == L_TX && !nxt_s && !dir_s && xrst_r)
      |=> (ls_r == L_TX) && $stable(ulpi_data_out))
      else $error("byte advanced without pace");
   a_stop_mark: assert property (
      (tick && ls_r == L_TX && nxt_s && !dir_s && !turn && xrst_r &&
       fq.data[8]) |=> link_stop && ulpi_data_out == BUS_IDLE)
      else $error("stream end not marked");
   a_ep_limit: assert property (
      (ls_r == L_IDLE) ##1 (ls_r == L_TX) |-> !$past(tx_ep_bad))
      else $error("endpoint above limit served");
   a_light_entry: assert property (
      (link_low(link_state) && !sw_suspend && partner_attached &&
       !sw_deep_req) |=> (ps_r == PS_LIGHT_CLOCK_GATED) ##1 !unit_clk_en)
      else $error("light state not entered");
   a_gated_ref: assert property (
      (ps_r == PS_POWER_GATED) [*2] |-> !xcvr_ref_clock)
      else $error("reference clock runs when gated");
   a_deep_by_sw: assert property (
      (ps_r != PS_DEEP) ##1 (ps_r == PS_DEEP)
      |-> $past(sw_deep_req) && $past(link_state) == LINK_U3)
      else $error("deep state without request");
   a_event_irq: assert property (
      (ev_valid && ev_ready) |=> ev_irq)
      else $error("delivery without interrupt");
   a_xrst_block: assert property (
      !xcvr_reset_n |=> ls_r != L_TX)
      else $error("transfer under transceiver reset");
endmodule : uls_link

// >>> uls_phy_model.sv
module uls_phy_model (
   output logic ulpi_clk,
   output logic [7:0] bus,
   input wire logic [7:0] link_data,
   input wire logic link_oe,
   output logic ulpi_dir,
   output logic xcvr_pace,
   input wire logic link_stop,
   input wire logic send_go
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];
   int pkts = 0;
   logic busy = 1'b0;
   logic stop_req = 1'b0;
   logic p_oe = 1'b0;
   logic [7:0] p_d = 8'h00;
   logic [7:0] last = 8'h00;

   initial ulpi_clk = 1'b0;
   initial ulpi_dir = 1'b0;
   initial xcvr_pace = 1'b0;
   always #400 ulpi_clk = ~ulpi_clk;

   // An undriven bus shows the inverse of its last value, never a copy.
   assign bus = p_oe ? p_d : (link_oe ? link_data : ~last);
   always @(bus) if (p_oe || link_oe) last = bus;

   always @(posedge ulpi_clk) begin
      if (ulpi_dir) begin
         if (link_stop) stop_req <= 1'b1;
      end else if (busy) begin
         if (link_stop) begin
            busy <= 1'b0;
            pkts++;
         end else if (xcvr_pace) got.push_back(bus);
      end else if (link_oe && bus != 8'h00) busy <= 1'b1;
   end

   always @(negedge ulpi_clk) if (!ulpi_dir) xcvr_pace = busy;

   // Outputs change on falling edges so they are steady around each tick.
   always @(posedge send_go) begin
      stop_req = 1'b0;
      @(negedge ulpi_clk) ulpi_dir = 1'b1;
      @(negedge ulpi_clk) begin
         p_oe = 1'b1;
         p_d = 8'hA5;
         xcvr_pace = 1'b1;
      end
      @(negedge ulpi_clk) begin
         p_d = 8'h5A;
         xcvr_pace = 1'b0;
      end
      while (!stop_req) @(negedge ulpi_clk);
      p_oe = 1'b0;
      ulpi_dir = 1'b0;
   end
endmodule : uls_phy_model

// >>> tb_usb_device_ulpi_link_side.sv
module tb_usb_device_ulpi_link_side
   import uls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [1:0] ls;
      logic su, pa, dr;
      logic [1:0] ps;
      logic ce, rr;
   } uls_row_s;
   logic sys_clk = 1'b0, rst_n = 1'b0, ulpi_clk, ulpi_dir, xcvr_pace;
   logic [7:0] ulpi_data_in, ulpi_data_out, tx_data = 8'h00, rx_data;
   logic ulpi_data_oe, link_stop, xcvr_ref_clock, xcvr_reset_n, tx_ready;
   logic xcvr_release = 1'b0, tx_last = 1'b0, tx_valid = 1'b0;
   logic [3:0] tx_ep = 4'h2;
   logic tx_ep_bad, bus_req = 1'b0, rx_cmd, rx_valid, sw_suspend = 1'b0;
   logic [1:0] link_state = LINK_U0, power_state, ev_code;
   logic partner_attached = 1'b1, sw_deep_req = 1'b0, unit_clk_en;
   logic ev_valid, ev_ready = 1'b0, ev_irq, send_go = 1'b0, r, pdir = 1'b0;
   logic [8:0] rxq[$];
   int err_count = 0, checks_done = 0, n, k;
   uls_row_s rows[8] = '{
      '{LINK_U1, 1'h0, 1'h1, 1'h0, PS_LIGHT_CLOCK_GATED, 1'h0, 1'h1},
      '{LINK_U2, 1'h0, 1'h1, 1'h0, PS_LIGHT_CLOCK_GATED, 1'h0, 1'h1},
      '{LINK_U0, 1'h0, 1'h1, 1'h0, PS_FULL, 1'h1, 1'h1},
      '{LINK_U3, 1'h0, 1'h1, 1'h1, PS_DEEP, 1'h0, 1'h0},
      '{LINK_U0, 1'h1, 1'h1, 1'h0, PS_POWER_GATED, 1'h0, 1'h0},
      '{LINK_U1, 1'h0, 1'h0, 1'h0, PS_POWER_GATED, 1'h0, 1'h0},
      '{LINK_U2, 1'h0, 1'h1, 1'h1, PS_LIGHT_CLOCK_GATED, 1'h0, 1'h1},
      '{LINK_U0, 1'h0, 1'h1, 1'h0, PS_FULL, 1'h1, 1'h1}};

   uls_link u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ulpi_clk(ulpi_clk),
      .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out),
      .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir),
      .xcvr_pace(xcvr_pace), .link_stop(link_stop),
      .xcvr_ref_clock(xcvr_ref_clock), .xcvr_reset_n(xcvr_reset_n),
      .xcvr_release(xcvr_release), .tx_data(tx_data), .tx_last(tx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ep(tx_ep),
      .tx_ep_bad(tx_ep_bad), .bus_req(bus_req), .rx_data(rx_data),
      .rx_cmd(rx_cmd), .rx_valid(rx_valid), .link_state(link_state),
      .sw_suspend(sw_suspend), .partner_attached(partner_attached),
      .sw_deep_req(sw_deep_req), .power_state(power_state),
      .unit_clk_en(unit_clk_en), .ev_valid(ev_valid), .ev_code(ev_code),
      .ev_ready(ev_ready), .ev_irq(ev_irq));
   uls_phy_model u_phy (.ulpi_clk(ulpi_clk), .bus(ulpi_data_in),
      .link_data(ulpi_data_out), .link_oe(ulpi_data_oe),
      .ulpi_dir(ulpi_dir), .xcvr_pace(xcvr_pace), .link_stop(link_stop),
      .send_go(send_go));

   always #50 sys_clk = ~sys_clk;

   task automatic chk(input logic [8:0] got, input logic [8:0] exp,
         input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) rxq.push_back({rx_cmd, rx_data});
   end

   always @(posedge ulpi_clk) begin
      if (pdir) chk(ulpi_data_oe, 9'h0, "drive in turnaround");
      pdir = ulpi_dir;
   end

   initial begin
      #1_000_000;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         @(negedge sys_clk);
         link_state = rows[i].ls;
         sw_suspend = rows[i].su;
         partner_attached = rows[i].pa;
         sw_deep_req = rows[i].dr;
         repeat (3) @(negedge sys_clk);
         chk(power_state, rows[i].ps, "power");
         chk(unit_clk_en, rows[i].ce, "unit clock");
         chk({ev_valid, ev_code}, {1'h1, rows[i].ls}, "event");
         r = xcvr_ref_clock;
         ev_ready = 1'b1;
         @(negedge sys_clk);
         ev_ready = 1'b0;
         chk(xcvr_ref_clock ^ r, rows[i].rr, "ref clock");
         chk({ev_valid, ev_irq}, 9'h1, "irq");
         @(negedge sys_clk);
         chk(ev_irq, 9'h0, "irq pulse");
      end
      // A second reset in mid-run must bring the pins back to rest.
      rst_n = 1'b0;
      @(negedge sys_clk);
      chk({xcvr_reset_n, ulpi_data_oe, tx_ready}, 9'h1, "rst pins");
      chk(power_state, PS_INIT, "reset power");
      rst_n = 1'b1;
      n = 0;
      @(negedge sys_clk);
      while (tx_ready === 1'b1 && n < 20) begin
         tx_data = 8'h40 + n[7:0];
         tx_last = (n[1:0] == 2'h3) || n >= 16;
         tx_valid = 1'b1;
         @(negedge sys_clk);
         n++;
      end
      tx_valid = 1'b0;
      chk(n, 9'd17, "fifo capacity");
      repeat (40) @(negedge sys_clk);
      chk({xcvr_reset_n, u_phy.got.size() != 0}, 9'h0, "held reset");
      tx_ep = 4'h8;
      xcvr_release = 1'b1;
      repeat (80) @(negedge sys_clk);
      chk({xcvr_reset_n, tx_ep_bad}, 9'h3, "bad endpoint");
      chk(u_phy.got.size(), 9'h0, "bad endpoint sent");
      tx_ep = 4'h7;
      for (k = 0; k < 3000 && u_phy.pkts < 5; k++) @(negedge sys_clk);
      chk(u_phy.pkts, 9'h5, "packets");
      chk(u_phy.got.size(), 9'd17, "byte count");
      foreach (u_phy.got[i]) begin
         chk(u_phy.got[i], 9'h40 + i[8:0], "tx byte");
      end
      repeat (20) @(negedge sys_clk);
      chk({ulpi_data_oe, ulpi_data_out}, 9'h100, "idle bus");
      send_go = 1'b1;
      for (k = 0; k < 100 && rxq.size() < 2; k++) @(negedge sys_clk);
      bus_req = 1'b1;
      for (k = 0; k < 100 && ulpi_dir !== 1'b0; k++) @(negedge sys_clk);
      bus_req = 1'b0;
      chk(ulpi_dir, 9'h0, "bus handed back");
      chk(rxq[0], 9'h0A5, "rx data");
      chk(rxq[1], 9'h15A, "rx status");
      print_verdict();
   end
endmodule : tb_usb_device_ulpi_link_side
